/* File: common/stepper_pkg.sv */
// shared constants and types for the stepper microstep sequencer
package stepper_pkg;

  // register byte offsets on the bus
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] CURRENT_OFFSET = 4'h8;

  // control register layout, low half of the word
  typedef struct packed {
    logic [7:0] setpoint;
    logic [2:0] reserved;
    logic rotation_direction;
    logic edge_select;
    logic step_mode_sel_hi;
    logic step_mode_sel_lo;
    logic enable;
  } ctrl_t;

  // drive off, full-scale setpoint
  localparam logic [15:0] CTRL_RESET = 16'hff00;

  // electrical position in sixteenths of a full step
  localparam logic [5:0] HOME_POSITION = 6'h08;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_SETTLE_US = 10;
  localparam int RESET_SETTLE_CYCLES =
    (RESET_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIR_HOLD_US = 7;
  localparam int DIR_HOLD_CYCLES = (DIR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // current ratios in percent
  localparam logic [6:0] RATIO_FULL = 7'h64;
  localparam logic [6:0] RATIO_TWO_PHASE_HALF = 7'h47;
  localparam logic [6:0] RATIO_TABLE [0:16] = '{
    7'h00, 7'h0b, 7'h14, 7'h1e, 7'h28, 7'h2f, 7'h37, 7'h40, 7'h47,
    7'h4d, 7'h53, 7'h57, 7'h5d, 7'h5f, 7'h61, 7'h64, 7'h64
  };

  typedef enum logic [2:0] {
    FULL_STEP = 3'b000,
    HALF_STEP = 3'b001,
    QUARTER_STEP = 3'b010,
    EIGHTH_STEP = 3'b011,
    SIXTEENTH_STEP = 3'b100
  } step_mode_t;

  typedef struct packed {
    logic phase_a;
    logic phase_ab;
    logic phase_b;
    logic phase_bb;
  } drive_t;

  function automatic step_mode_t decode_mode(input ctrl_t c);
    logic [1:0] code;
    code = {c.step_mode_sel_hi, c.step_mode_sel_lo};
    if (c.edge_select) begin
      case (code)
        2'b00: decode_mode = FULL_STEP;
        2'b01: decode_mode = HALF_STEP;
        2'b10: decode_mode = QUARTER_STEP;
        default: decode_mode = EIGHTH_STEP;
      endcase
    end else begin
      case (code)
        2'b00: decode_mode = HALF_STEP;
        2'b01: decode_mode = QUARTER_STEP;
        2'b10: decode_mode = EIGHTH_STEP;
        default: decode_mode = SIXTEENTH_STEP;
      endcase
    end
  endfunction

  function automatic logic [5:0] step_size(input step_mode_t m);
    case (m)
      FULL_STEP: step_size = 6'h10;
      HALF_STEP: step_size = 6'h08;
      QUARTER_STEP: step_size = 6'h04;
      EIGHTH_STEP: step_size = 6'h02;
      default: step_size = 6'h01;
    endcase
  endfunction

endpackage

/* File: logic/phase_current_scaler.sv */
// per-phase current ratio lookup and setpoint scaling
`timescale 1ns/1ps
module phase_current_scaler
  import stepper_pkg::*;
(
  // table indices, sixteenths from the phase zero
  input wire logic [4:0] idx_a_i,
  input wire logic [4:0] idx_b_i,
  input wire logic force_full_i,
  input wire logic [7:0] setpoint_i,
  // results
  output logic [6:0] ratio_a_o,
  output logic [6:0] ratio_b_o,
  output logic [7:0] current_a_o,
  output logic [7:0] current_b_o
);

  function automatic logic [6:0] ratio_of(input logic [4:0] idx, input logic force_full);
    logic [6:0] r;
    r = (idx > 5'h10) ? 7'h00 : RATIO_TABLE[idx];
    if (force_full && r != 7'h00) begin
      r = RATIO_FULL;
    end
    ratio_of = r;
  endfunction

  // ratio is at most 100, so the quotient never exceeds the setpoint
  function automatic logic [7:0] scale(input logic [7:0] sp, input logic [6:0] ratio);
    logic [14:0] prod;
    // widen before the product so a high setpoint does not wrap
    prod = 15'(sp) * 15'(ratio);
    scale = 8'(prod / 15'(RATIO_FULL));
  endfunction

  always_comb begin
    ratio_a_o = ratio_of(idx_a_i, force_full_i);
    ratio_b_o = ratio_of(idx_b_i, force_full_i);
    current_a_o = scale(setpoint_i, ratio_a_o);
    current_b_o = scale(setpoint_i, ratio_b_o);
  end

endmodule // phase_current_scaler

/* File: logic/stepper_microstep_sequencer.sv */
// step sequencer with wishbone control and microstep current output
`timescale 1ns/1ps
module stepper_microstep_sequencer
  import stepper_pkg::*;
#(
  parameter int SETTLE_CYCLES = RESET_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // step controller pins
  input wire logic STEP_CLOCK_I,
  input wire logic SYSTEM_RESET_N_I,
  // motor side
  output drive_t DRIVE_O,
  output logic [7:0] PHASE_A_CURRENT_O,
  output logic [7:0] PHASE_B_CURRENT_O
);

  typedef struct packed {
    ctrl_t ctrl;
    logic [5:0] pos;
    logic clk_last;
    logic [11:0] settle;
    logic ack;
    logic [31:0] rdata;
    drive_t drive;
    logic [6:0] ratio_a;
    logic [6:0] ratio_b;
    logic [7:0] cur_a;
    logic [7:0] cur_b;
  } state_t;

  state_t s;
  state_t next_s;

  step_mode_t mode;
  logic wb_req;
  logic rise;
  logic fall;
  logic settled;
  logic step_evt;
  logic force_full;
  logic [1:0] quad;
  logic [3:0] frac;
  logic [4:0] idx_a;
  logic [4:0] idx_b;
  logic [6:0] ratio_a;
  logic [6:0] ratio_b;
  logic [7:0] cur_a;
  logic [7:0] cur_b;

  assign mode = decode_mode(s.ctrl);
  assign wb_req = WB_CYC_I && WB_STB_I && !s.ack;
  assign rise = STEP_CLOCK_I && !s.clk_last;
  assign fall = !STEP_CLOCK_I && s.clk_last;
  assign settled = (s.settle == 12'h000);
  // disabled block ignores the step clock; edges during settling are dropped
  assign step_evt = s.ctrl.enable && settled && SYSTEM_RESET_N_I &&
    (rise || (!s.ctrl.edge_select && fall));
  // plain half step and full step run at the full setting
  assign force_full = (mode == FULL_STEP) ||
    (mode == HALF_STEP && s.ctrl.edge_select);

  // odd quadrants swap which phase sees the cosine
  assign quad = s.pos[5:4];
  assign frac = s.pos[3:0];
  assign idx_a = quad[0] ? {1'b0, frac} : 5'(5'h10 - {1'b0, frac});
  assign idx_b = quad[0] ? 5'(5'h10 - {1'b0, frac}) : {1'b0, frac};

  phase_current_scaler scaler (
    .idx_a_i(idx_a),
    .idx_b_i(idx_b),
    .force_full_i(force_full),
    .setpoint_i(s.ctrl.setpoint),
    .ratio_a_o(ratio_a),
    .ratio_b_o(ratio_b),
    .current_a_o(cur_a),
    .current_b_o(cur_b)
  );

  always_comb begin
    next_s = s;
    next_s.ack = wb_req;
    next_s.clk_last = STEP_CLOCK_I;

    if (wb_req && WB_WE_I && WB_ADR_I == CTRL_OFFSET) begin
      if (WB_SEL_I[0]) begin
        next_s.ctrl[7:0] = WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        next_s.ctrl[15:8] = WB_DAT_I[15:8];
      end
      next_s.ctrl.reserved = 3'h0;
    end

    case (WB_ADR_I)
      CTRL_OFFSET: next_s.rdata = {16'h0000, s.ctrl};
      STATUS_OFFSET: next_s.rdata = {21'h00_0000, mode, 1'b0, settled, s.pos};
      CURRENT_OFFSET: next_s.rdata = {s.cur_b, s.cur_a, 1'b0, s.ratio_b, 1'b0, s.ratio_a};
      default: next_s.rdata = 32'h0000_0000;
    endcase

    if (!SYSTEM_RESET_N_I) begin
      next_s.pos = HOME_POSITION;
      next_s.settle = 12'(SETTLE_CYCLES);
    end else begin
      if (!settled) begin
        next_s.settle = 12'(s.settle - 12'h001);
      end
      if (step_evt) begin
        // direction sampled at the edge; the controller keeps it steady there
        if (s.ctrl.rotation_direction) begin
          next_s.pos = 6'(s.pos - step_size(mode));
        end else begin
          next_s.pos = 6'(s.pos + step_size(mode));
        end
      end
    end

    // position is kept while off, unless the motor reset pin homes it, so the excitation phase survives
    next_s.drive.phase_a = s.ctrl.enable && (quad == 2'b00 || quad == 2'b11) &&
      ratio_a != 7'h00;
    next_s.drive.phase_ab = s.ctrl.enable && (quad == 2'b01 || quad == 2'b10) &&
      ratio_a != 7'h00;
    next_s.drive.phase_b = s.ctrl.enable && !quad[1] && ratio_b != 7'h00;
    next_s.drive.phase_bb = s.ctrl.enable && quad[1] && ratio_b != 7'h00;
    next_s.ratio_a = ratio_a;
    next_s.ratio_b = ratio_b;
    next_s.cur_a = s.ctrl.enable ? cur_a : 8'h00;
    next_s.cur_b = s.ctrl.enable ? cur_b : 8'h00;
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.pos <= HOME_POSITION;
      s.settle <= 12'(SETTLE_CYCLES);
    end else begin
      s <= next_s;
    end
  end

  assign WB_DAT_O = s.rdata;
  assign WB_ACK_O = s.ack;
  assign DRIVE_O = s.drive;
  assign PHASE_A_CURRENT_O = s.cur_a;
  assign PHASE_B_CURRENT_O = s.cur_b;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SYS_RST_I);

  sequence bus_request;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence

  sequence one_cycle_ack;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  bus_ack_once_a: assert property (bus_request |=> one_cycle_ack)
    else $error("bus ack not a single cycle after request");

  rise_step_a: assert property (step_evt && rise && !s.ctrl.rotation_direction
    && SYSTEM_RESET_N_I |=> s.pos == 6'($past(s.pos) + step_size($past(mode))))
    else $error("rising edge did not advance by the step size");

  fall_ignored_a: assert property (s.ctrl.edge_select && fall && !rise
    && SYSTEM_RESET_N_I |=> $stable(s.pos))
    else $error("falling edge moved position in rising-only mode");

  reverse_step_a: assert property (step_evt && s.ctrl.rotation_direction
    && SYSTEM_RESET_N_I |=> s.pos == 6'($past(s.pos) - step_size($past(mode))))
    else $error("reverse direction did not step backward");

  sixteenth_table_a: assert property (mode == SIXTEENTH_STEP && s.pos == 6'h09
    |=> s.ratio_b == 7'h4d && s.ratio_a == 7'h40)
    else $error("table ratio wrong at ninth sixteenth");

  plain_half_full_a: assert property (mode == HALF_STEP && s.ctrl.edge_select
    && frac == 4'h8 |=> s.ratio_a == RATIO_FULL && s.ratio_b == RATIO_FULL)
    else $error("rising-only half step not at full current");

  pseudo_micro_a: assert property (mode == HALF_STEP && !s.ctrl.edge_select
    && frac == 4'h8 |=> s.ratio_a == RATIO_TWO_PHASE_HALF)
    else $error("pseudo micro two-phase level not reduced");

  disable_off_a: assert property (!s.ctrl.enable |=> s.drive == 4'h0
    && s.cur_a == 8'h00 && s.cur_b == 8'h00)
    else $error("drive active while disabled");

  disable_frozen_a: assert property (!s.ctrl.enable && SYSTEM_RESET_N_I
    |=> $stable(s.pos))
    else $error("position moved while disabled");

  settle_hold_a: assert property (!SYSTEM_RESET_N_I ##1 SYSTEM_RESET_N_I
    |-> !step_evt && s.settle == 12'(SETTLE_CYCLES))
    else $error("step accepted right after reset release");

  scale_full_a: assert property (s.ctrl.enable && $stable(s.ctrl) && s.ratio_a == RATIO_FULL
    && $past(s.ratio_a) == RATIO_FULL |-> s.cur_a == s.ctrl.setpoint)
    else $error("full ratio does not equal setpoint");

endmodule // stepper_microstep_sequencer

/* File: verification/step_ctrl.sv */
// step controller model driving the step clock and motor reset pins
`timescale 1ns/1ps
module step_ctrl #(
  parameter int SETTLE = 8,
  parameter int HOLD = 4
) (
  input wire logic clk_i,
  output logic step_clock_o,
  output logic reset_n_o
);
  initial begin
    step_clock_o = 1'b0;
    reset_n_o = 1'b1;
  end
  // settings stay still for HOLD cycles around every edge
  task automatic toggle();
    repeat (HOLD) @(posedge clk_i);
    step_clock_o <= ~step_clock_o;
    repeat (HOLD) @(posedge clk_i);
  endtask
  task automatic motor_reset();
    @(posedge clk_i);
    reset_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_o <= 1'b1;
    repeat (SETTLE + 2) @(posedge clk_i);
  endtask
endmodule // step_ctrl

/* File: verification/tb.sv */
// self-checking bench for the stepper microstep sequencer
`timescale 1ns/1ps
module tb;
  import stepper_pkg::*;
  localparam int SETTLE = 8;
  localparam logic [6:0] TBL [0:16] = '{7'h00, 7'h0b, 7'h14, 7'h1e, 7'h28, 7'h2f, 7'h37,
    7'h40, 7'h47, 7'h4d, 7'h53, 7'h57, 7'h5d, 7'h5f, 7'h61, 7'h64, 7'h64};
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic step_clk, mrst_n;
  drive_t drv;
  logic [7:0] cur_a, cur_b;
  int mismatches = 0, num_checks = 0, cycles = 0;
  logic [5:0] pos;

  stepper_microstep_sequencer #(.SETTLE_CYCLES(SETTLE)) u_dut (.CLOCK_I(clk), .SYS_RST_I(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .STEP_CLOCK_I(step_clk),
    .SYSTEM_RESET_N_I(mrst_n), .DRIVE_O(drv), .PHASE_A_CURRENT_O(cur_a),
    .PHASE_B_CURRENT_O(cur_b));
  step_ctrl #(.SETTLE(SETTLE)) u_ctrl (.clk_i(clk), .step_clock_o(step_clk), .reset_n_o(mrst_n));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang counts against the run rather than stalling it
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic chk4(input drive_t got, input drive_t exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // expected CURRENT word with setpoint 100, so currents equal ratios
  function automatic logic [31:0] exp_cur(input logic [5:0] p, input logic full);
    logic [4:0] ia, ib;
    logic [6:0] ra, rb;
    ia = p[4] ? {1'b0, p[3:0]} : 5'h10 - {1'b0, p[3:0]};
    ib = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
    ra = TBL[ia];
    rb = TBL[ib];
    if (full && ra != 7'h00) ra = 7'h64;
    if (full && rb != 7'h00) rb = 7'h64;
    return {1'b0, rb, 1'b0, ra, 1'b0, rb, 1'b0, ra};
  endfunction
  function automatic drive_t exp_drv(input logic [5:0] p, input logic [31:0] c);
    logic na, nb;
    na = c[6:0] != 7'h00;
    nb = c[14:8] != 7'h00;
    return {na && (p[5:4] == 2'h0 || p[5:4] == 2'h3), na && (p[5:4] == 2'h1 || p[5:4] == 2'h2),
      nb && !p[5], nb && p[5]};
  endfunction

  task automatic step_chk(input logic full);
    logic [31:0] e;
    u_ctrl.toggle();
    wb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk32(q & 32'h0000_003f, {26'h0, pos});
    e = exp_cur(pos, full);
    wb(1'b0, CURRENT_OFFSET, 32'h0000_0000);
    chk32(q, e);
    chk32({16'h0000, cur_b, cur_a}, {16'h0000, e[31:16]});
    chk4(drv, exp_drv(pos, e));
  endtask

  task automatic t_reset();
    wb(1'b0, CTRL_OFFSET, 32'h0000_0000);
    chk32(q, 32'h0000_ff00);
    wb(1'b0, 4'hc, 32'h0000_0000);
    chk32(q, 32'h0000_0000);
    chk4(drv, 4'h0);
  endtask
  task automatic t_modes();
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, CTRL_OFFSET, {24'h0000_64, 4'h0, 3'(i), 1'b0});
      wb(1'b0, STATUS_OFFSET, 32'h0000_0000);
      chk32((q >> 8) & 32'h0000_0007, i[2] ? 32'(i[1:0]) : 32'(i[1:0]) + 1);
    end
  endtask
  task automatic t_sixteenth();
    wb(1'b1, CTRL_OFFSET, 32'h0000_6407);
    for (int i = 0; i < 18; i++) begin
      pos = pos + 6'h01;
      step_chk(1'b0);
    end
  endtask
  task automatic t_rise_half();
    wb(1'b1, CTRL_OFFSET, 32'h0000_640b);
    pos = pos + 6'h08;
    step_chk(1'b1);
    step_chk(1'b1);
  endtask
  task automatic t_pseudo_reverse();
    wb(1'b1, CTRL_OFFSET, 32'h0000_6401);
    u_ctrl.motor_reset();
    pos = 6'h10;
    step_chk(1'b0);
    pos = 6'h18;
    step_chk(1'b0);
    wb(1'b1, CTRL_OFFSET, 32'h0000_c801);
    wb(1'b0, CURRENT_OFFSET, 32'h0000_0000);
    chk32(q, 32'h8e8e_4747);
    chk32({16'h0000, cur_b, cur_a}, 32'h0000_8e8e);
    wb(1'b1, CTRL_OFFSET, 32'h0000_6417);
    pos = 6'h17;
    step_chk(1'b0);
  endtask
  task automatic t_disable();
    wb(1'b1, CTRL_OFFSET, 32'h0000_6416);
    u_ctrl.toggle();
    wb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk32(q & 32'h0000_003f, {26'h0, pos});
    wb(1'b0, CURRENT_OFFSET, 32'h0000_0000);
    chk32(q & 32'hffff_0000, 32'h0000_0000);
    chk32({16'h0000, cur_b, cur_a}, 32'h0000_0000);
    chk4(drv, 4'h0);
  endtask

  initial begin
    pos = HOME_POSITION;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (SETTLE + 2) @(posedge clk);
    t_reset();
    t_modes();
    t_sixteenth();
    t_rise_half();
    t_pseudo_reverse();
    t_disable();
    close_out();
  end
endmodule // tb
